// *** hw/edge_if.sv ***
`timescale 1ns/1ps
// Signals between the register file and one port's detector
interface edge_if;
  logic [gpio_bank_pkg::PORT_W-1:0] src;
  logic [gpio_bank_pkg::PORT_W-1:0] mask;
  logic [gpio_bank_pkg::PORT_W-1:0] edge_sel;
  logic [gpio_bank_pkg::PORT_W-1:0] both;
  logic [gpio_bank_pkg::PORT_W-1:0] clr;
  logic [gpio_bank_pkg::PORT_W-1:0] flag;
  logic irq;
  modport unit (input src, mask, edge_sel, both, clr, output flag, irq);
  modport ctrl (output src, mask, edge_sel, both, clr, input flag, irq);
endinterface

// *** hw/gpio_bank_pkg.sv ***
// How it works
// - 48 two-way general pins, split over three port modules of 16.
// - The fourth port has no general pin logic, only peripheral paths.
// - After reset every shareable pin selects the general pin function.
// - After reset output drivers and input buffers stay off until enabled.
// - A direction register holds one bit per pin, input or output.
// - Set, clear and toggle writes change only pins written with one.
// - Ones written to set drive pins high; to clear drive them low.
// - Ones written to toggle invert those pins in a single write.
// - A data register loads the whole output pattern as written.
// - Reading the status register returns the sensed level of each pin with input buffer on and general function; others read zero.
// - Mask-set ones enable pin interrupts; mask-clear ones disable them.
// - Input pins raise interrupts; output pins by software value writes.
// - A per-pin sensitivity bit picks level or edge detection.
// - For edge pins, a second bit picks rising only or both edges.
package gpio_bank_pkg;
  localparam int PORT_W = 16;
  localparam int NUM_PORTS = 3;
  localparam int BANK_W = 48;
  // Register offsets inside one port window of 64 bytes
  localparam logic [5:0] OFF_DATA = 6'h00;
  localparam logic [5:0] OFF_CLEAR = 6'h04;
  localparam logic [5:0] OFF_SET = 6'h08;
  localparam logic [5:0] OFF_TOGGLE = 6'h0c;
  localparam logic [5:0] OFF_MASK = 6'h10;
  localparam logic [5:0] OFF_MASK_CLR = 6'h14;
  localparam logic [5:0] OFF_MASK_SET = 6'h18;
  localparam logic [5:0] OFF_DIR = 6'h1c;
  localparam logic [5:0] OFF_SENS = 6'h20;
  localparam logic [5:0] OFF_BOTH = 6'h24;
  localparam logic [5:0] OFF_INEN = 6'h28;
  localparam logic [5:0] OFF_STATUS = 6'h2c;
  localparam logic [5:0] OFF_FLAG = 6'h30;
  localparam logic [5:0] OFF_FUNC = 6'h34;
  localparam logic [5:0] OFF_LAST = 6'h34;
  localparam logic [1:0] LAST_PORT = 2'h2;
  // Reset value of every control register
  localparam logic [15:0] RST_ZERO = 16'h0000;
  typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_READ, PH_RDATA} bus_phase_t;
endpackage

// *** hw/gpio_edge_unit.sv ***
`timescale 1ns/1ps
module gpio_edge_unit (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Detector signals
  edge_if.unit eif
);
  import gpio_bank_pkg::*;
  logic [PORT_W-1:0] prev_r, prev_nxt;
  logic [PORT_W-1:0] flag_r, flag_nxt;
  logic [PORT_W-1:0] rise, fall;
  logic irq_r, irq_nxt;

  // Edge capture, sticky flags and the masked request
  always_comb begin
    rise = eif.src & ~prev_r;
    fall = ~eif.src & prev_r;
    prev_nxt = eif.src;
    // A new edge wins over a clear in the same cycle
    flag_nxt = (flag_r & ~eif.clr) |
               (eif.edge_sel & (rise | (eif.both & fall)));
    irq_nxt = |(eif.mask & ((eif.edge_sel & flag_r) |
                            (~eif.edge_sel & eif.src)));
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      prev_r <= RST_ZERO;
      flag_r <= RST_ZERO;
      irq_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      flag_r <= flag_nxt;
      irq_r <= irq_nxt;
    end
  end
  assign eif.flag = flag_r;
  assign eif.irq = irq_r;

  level_irq_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    |(~eif.edge_sel & eif.mask & eif.src) |=> irq_r)
    else $error("level pin did not raise request");
  masked_off_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    eif.mask == RST_ZERO |=> !irq_r)
    else $error("request with all pins masked");

  for (genvar i = 0; i < PORT_W; i++) begin : g_chk
    rise_flag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      rise[i] && eif.edge_sel[i] |=> flag_r[i])
      else $error("rising edge not flagged");
    fall_only_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
      fall[i] && eif.edge_sel[i] && !eif.both[i] && !flag_r[i]
      |=> !flag_r[i])
      else $error("falling edge flagged in rising-only mode");
  end
endmodule

// *** hw/gpio_port_bank.sv ***
`timescale 1ns/1ps
module gpio_port_bank (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RSTN_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // General pins of the three port modules
  input wire logic [gpio_bank_pkg::BANK_W-1:0] PIN_IN,
  output logic [gpio_bank_pkg::BANK_W-1:0] PIN_OUT,
  output logic [gpio_bank_pkg::BANK_W-1:0] PIN_OE_OUT,
  // Peripheral side of the shared pins
  input wire logic [gpio_bank_pkg::BANK_W-1:0] PERIPH_OUT_IN,
  input wire logic [gpio_bank_pkg::BANK_W-1:0] PERIPH_OE_IN,
  output logic [gpio_bank_pkg::BANK_W-1:0] PERIPH_IN_OUT,
  // Fourth port, peripheral only
  input wire logic [gpio_bank_pkg::PORT_W-1:0] PJ_PIN_IN,
  output logic [gpio_bank_pkg::PORT_W-1:0] PJ_PIN_OUT,
  output logic [gpio_bank_pkg::PORT_W-1:0] PJ_PIN_OE_OUT,
  input wire logic [gpio_bank_pkg::PORT_W-1:0] PJ_PERIPH_OUT_IN,
  input wire logic [gpio_bank_pkg::PORT_W-1:0] PJ_PERIPH_OE_IN,
  output logic [gpio_bank_pkg::PORT_W-1:0] PJ_PERIPH_IN_OUT,
  // Per-port interrupt requests
  output logic [gpio_bank_pkg::NUM_PORTS-1:0] IRQ_OUT
);
  import gpio_bank_pkg::*;

  typedef logic [PORT_W-1:0] word_t;

  bus_phase_t phase_r, phase_nxt;
  logic [1:0] wp_r, wp_nxt;
  logic [5:0] off_r, off_nxt;
  logic map_r, map_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic take;
  logic wr_go;
  word_t wd;
  word_t rd_val;

  word_t out_r [NUM_PORTS];
  word_t out_nxt [NUM_PORTS];
  word_t dir_r [NUM_PORTS];
  word_t dir_nxt [NUM_PORTS];
  word_t inen_r [NUM_PORTS];
  word_t inen_nxt [NUM_PORTS];
  word_t mask_r [NUM_PORTS];
  word_t mask_nxt [NUM_PORTS];
  word_t sens_r [NUM_PORTS];
  word_t sens_nxt [NUM_PORTS];
  word_t both_r [NUM_PORTS];
  word_t both_nxt [NUM_PORTS];
  word_t func_r [NUM_PORTS];
  word_t func_nxt [NUM_PORTS];
  word_t clr [NUM_PORTS];
  word_t sync_q [NUM_PORTS];
  word_t sensed [NUM_PORTS];
  word_t src [NUM_PORTS];
  word_t flag [NUM_PORTS];
  logic [NUM_PORTS-1:0] irq;

  logic [BANK_W-1:0] pin_out_r, pin_out_nxt;
  logic [BANK_W-1:0] pin_oe_r, pin_oe_nxt;
  logic [BANK_W-1:0] p_in_r, p_in_nxt;
  logic [PORT_W-1:0] pj_out_r, pj_oe_r, pj_in_r;

  // Mapped register inside one of the three port windows
  function automatic logic reg_ok(input logic [31:0] a);
    return (a[31:8] == 24'h0) && (a[7:6] <= LAST_PORT) &&
           (a[5:0] <= OFF_LAST);
  endfunction

  // Bus phase tracking; reads take one wait state
  always_comb begin
    take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
    phase_nxt = PH_IDLE;
    wp_nxt = wp_r;
    off_nxt = off_r;
    map_nxt = map_r;
    hrdata_nxt = hrdata_r;
    if (phase_r == PH_READ) begin
      phase_nxt = PH_RDATA;
      hrdata_nxt = {16'h0000, rd_val};
    end else if (take) begin
      phase_nxt = HWRITE_IN ? PH_WRITE : PH_READ;
      wp_nxt = HADDR_IN[7:6];
      off_nxt = HADDR_IN[5:0];
      map_nxt = reg_ok(HADDR_IN);
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      phase_r <= PH_IDLE;
      wp_r <= 2'h0;
      off_r <= 6'h00;
      map_r <= 1'b0;
      hrdata_r <= 32'h0000_0000;
    end else begin
      phase_r <= phase_nxt;
      wp_r <= wp_nxt;
      off_r <= off_nxt;
      map_r <= map_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  assign HREADYOUT_OUT = (phase_r != PH_READ);
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = hrdata_r;
  assign wr_go = (phase_r == PH_WRITE) && map_r;
  assign wd = HWDATA_IN[PORT_W-1:0];

  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_val = RST_ZERO;
    if (map_r) begin
      case (off_r)
        OFF_DATA, OFF_CLEAR, OFF_SET, OFF_TOGGLE: rd_val = out_r[wp_r];
        OFF_MASK, OFF_MASK_CLR, OFF_MASK_SET: rd_val = mask_r[wp_r];
        OFF_DIR: rd_val = dir_r[wp_r];
        OFF_SENS: rd_val = sens_r[wp_r];
        OFF_BOTH: rd_val = both_r[wp_r];
        OFF_INEN: rd_val = inen_r[wp_r];
        OFF_STATUS: rd_val = sensed[wp_r];
        OFF_FLAG: rd_val = flag[wp_r];
        OFF_FUNC: rd_val = func_r[wp_r];
        default: rd_val = RST_ZERO;
      endcase
    end
  end

  // Control registers of the three port modules
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      out_nxt[p] = out_r[p];
      dir_nxt[p] = dir_r[p];
      inen_nxt[p] = inen_r[p];
      mask_nxt[p] = mask_r[p];
      sens_nxt[p] = sens_r[p];
      both_nxt[p] = both_r[p];
      func_nxt[p] = func_r[p];
      clr[p] = RST_ZERO;
      if (wr_go && (wp_r == 2'(p))) begin
        case (off_r)
          OFF_DATA: out_nxt[p] = wd;
          OFF_CLEAR: out_nxt[p] = out_r[p] & ~wd;
          OFF_SET: out_nxt[p] = out_r[p] | wd;
          OFF_TOGGLE: out_nxt[p] = out_r[p] ^ wd;
          OFF_MASK: mask_nxt[p] = wd;
          OFF_MASK_CLR: mask_nxt[p] = mask_r[p] & ~wd;
          OFF_MASK_SET: mask_nxt[p] = mask_r[p] | wd;
          OFF_DIR: dir_nxt[p] = wd;
          OFF_SENS: sens_nxt[p] = wd;
          OFF_BOTH: both_nxt[p] = wd;
          OFF_INEN: inen_nxt[p] = wd;
          OFF_FLAG: clr[p] = wd;
          OFF_FUNC: func_nxt[p] = wd;
          default: ;
        endcase
      end
    end
  end

  // Everything off and general function selected at reset
  always_ff @(posedge REF_CLK_IN) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (!RSTN_IN) begin
        out_r[p] <= RST_ZERO;
        dir_r[p] <= RST_ZERO;
        inen_r[p] <= RST_ZERO;
        mask_r[p] <= RST_ZERO;
        sens_r[p] <= RST_ZERO;
        both_r[p] <= RST_ZERO;
        func_r[p] <= RST_ZERO;
      end else begin
        out_r[p] <= out_nxt[p];
        dir_r[p] <= dir_nxt[p];
        inen_r[p] <= inen_nxt[p];
        mask_r[p] <= mask_nxt[p];
        sens_r[p] <= sens_nxt[p];
        both_r[p] <= both_nxt[p];
        func_r[p] <= func_nxt[p];
      end
    end
  end

  // Sensed levels and interrupt sources per port
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      sensed[p] = sync_q[p] & inen_r[p] & ~func_r[p];
      src[p] = (dir_r[p] & out_r[p]) | (~dir_r[p] & sensed[p]);
    end
  end

  // One synchroniser and detector per port module
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    edge_if eif ();
    gpio_sync2 u_sync (
      .clk_in(REF_CLK_IN),
      .rstn_in(RSTN_IN),
      .d_in(PIN_IN[p*PORT_W +: PORT_W]),
      .q_out(sync_q[p])
    );
    assign eif.src = src[p];
    assign eif.mask = mask_r[p];
    assign eif.edge_sel = sens_r[p];
    assign eif.both = both_r[p];
    assign eif.clr = clr[p];
    assign flag[p] = eif.flag;
    assign irq[p] = eif.irq;
    gpio_edge_unit u_edge (
      .clk_in(REF_CLK_IN),
      .rstn_in(RSTN_IN),
      .eif(eif)
    );
  end
  assign IRQ_OUT = irq;

  // Pin multiplexer: general function unless the select bit is set
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      for (int b = 0; b < PORT_W; b++) begin
        pin_out_nxt[p*PORT_W+b] = func_r[p][b] ?
          PERIPH_OUT_IN[p*PORT_W+b] : out_r[p][b];
        pin_oe_nxt[p*PORT_W+b] = func_r[p][b] ?
          PERIPH_OE_IN[p*PORT_W+b] : dir_r[p][b];
        p_in_nxt[p*PORT_W+b] = func_r[p][b] & sync_q[p][b];
      end
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      pin_out_r <= {BANK_W{1'b0}};
      pin_oe_r <= {BANK_W{1'b0}};
      p_in_r <= {BANK_W{1'b0}};
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      p_in_r <= p_in_nxt;
    end
  end
  assign PIN_OUT = pin_out_r;
  assign PIN_OE_OUT = pin_oe_r;
  assign PERIPH_IN_OUT = p_in_r;

  // Fourth port carries peripheral signals only
  always_ff @(posedge REF_CLK_IN) begin
    if (!RSTN_IN) begin
      pj_out_r <= RST_ZERO;
      pj_oe_r <= RST_ZERO;
      pj_in_r <= RST_ZERO;
    end else begin
      pj_out_r <= PJ_PERIPH_OUT_IN;
      pj_oe_r <= PJ_PERIPH_OE_IN;
      pj_in_r <= PJ_PIN_IN;
    end
  end
  assign PJ_PIN_OUT = pj_out_r;
  assign PJ_PIN_OE_OUT = pj_oe_r;
  assign PJ_PERIPH_IN_OUT = pj_in_r;

  // Helper state for the checks below
  logic [1:0] chk_port_r;
  word_t cur_out, chk_out, cur_mask, chk_mask;
  always_ff @(posedge REF_CLK_IN) begin
    chk_port_r <= wp_r;
  end
  assign cur_out = out_r[wp_r];
  assign chk_out = out_r[chk_port_r];
  assign cur_mask = mask_r[wp_r];
  assign chk_mask = mask_r[chk_port_r];

  sequence rd_taken;
    HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN;
  endsequence
  sequence rd_answer;
    !HREADYOUT_OUT ##1 HREADYOUT_OUT;
  endsequence

  pin_reset_a: assert property (@(posedge REF_CLK_IN)
    $rose(RSTN_IN) |-> PIN_OE_OUT == '0 && inen_r[0] == RST_ZERO)
    else $error("driver or input enabled after reset");
  func_reset_a: assert property (@(posedge REF_CLK_IN)
    $rose(RSTN_IN) |-> func_r[1] == RST_ZERO && func_r[2] == RST_ZERO)
    else $error("peripheral function selected after reset");
  read_wait_a: assert property (@(posedge REF_CLK_IN) disable iff (!RSTN_IN)
    rd_taken |=> rd_answer)
    else $error("read answer not after one wait state");
  out_set_a: assert property (@(posedge REF_CLK_IN)
    disable iff (!RSTN_IN)
    wr_go && off_r == OFF_SET |=> chk_out == ($past(cur_out) | $past(wd)))
    else $error("set write wrong");
  out_clear_a: assert property (@(posedge REF_CLK_IN)
    disable iff (!RSTN_IN)
    wr_go && off_r == OFF_CLEAR |=> chk_out == ($past(cur_out) & ~$past(wd)))
    else $error("clear write wrong");
  out_toggle_a: assert property (@(posedge REF_CLK_IN)
    disable iff (!RSTN_IN)
    wr_go && off_r == OFF_TOGGLE |=> chk_out == ($past(cur_out) ^ $past(wd)))
    else $error("toggle write wrong");
  out_write_a: assert property (@(posedge REF_CLK_IN)
    disable iff (!RSTN_IN)
    wr_go && off_r == OFF_DATA |=> chk_out == $past(wd))
    else $error("data write wrong");
  mask_set_a: assert property (@(posedge REF_CLK_IN)
    disable iff (!RSTN_IN)
    wr_go && off_r == OFF_MASK_SET
    |=> chk_mask == ($past(cur_mask) | $past(wd)))
    else $error("mask set wrong");
  mask_clr_a: assert property (@(posedge REF_CLK_IN)
    disable iff (!RSTN_IN)
    wr_go && off_r == OFF_MASK_CLR
    |=> chk_mask == ($past(cur_mask) & ~$past(wd)))
    else $error("mask clear wrong");
  status_read_a: assert property (@(posedge REF_CLK_IN)
    disable iff (!RSTN_IN)
    phase_r == PH_READ && map_r && off_r == OFF_STATUS
    |=> HRDATA_OUT == {16'h0000, $past(sensed[0] | sensed[1] | sensed[2]) &
                       $past(sensed[wp_r])})
    else $error("status read wrong");
endmodule

// *** hw/gpio_sync2.sv ***
`timescale 1ns/1ps
module gpio_sync2 (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Pin levels
  input wire logic [gpio_bank_pkg::PORT_W-1:0] d_in,
  output logic [gpio_bank_pkg::PORT_W-1:0] q_out
);
  import gpio_bank_pkg::*;
  logic [PORT_W-1:0] meta_r;
  logic [PORT_W-1:0] q_r;

  // Two flops; only the second reads the first
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      meta_r <= RST_ZERO;
      q_r <= RST_ZERO;
    end else begin
      meta_r <= d_in;
      q_r <= meta_r;
    end
  end
  assign q_out = q_r;

  sync_delay_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $past(rstn_in) && $past(rstn_in, 2) |-> q_out == $past(d_in, 2))
    else $error("synchroniser delay is not two cycles");
endmodule

// *** sim/board_model.sv ***
`timescale 1ns/1ps
module board_model (
  // Design side of the pins
  input wire logic [47:0] pin_out_in,
  input wire logic [47:0] pin_oe_in,
  // Board drive pattern
  input wire logic [47:0] drive_in,
  // Resolved pin level
  output logic [47:0] pin_level_out
);
  // Design wins where it drives, the board holds every other pin
  always_comb begin
    pin_level_out = (pin_out_in & pin_oe_in) | (drive_in & ~pin_oe_in);
  end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ps
module tb;
  import gpio_bank_pkg::*;
  typedef struct packed {
    logic [5:0] wo;
    logic [15:0] wd;
    logic [5:0] ro;
    logic [15:0] ex;
  } row_t;
  // Write then read back on the first port, set, clear and toggle rows build on the register's last value
  localparam row_t ROWS [9] = '{
    '{OFF_DATA, 16'h00ff, OFF_DATA, 16'h00ff},
    '{OFF_SET, 16'h0f00, OFF_DATA, 16'h0fff},
    '{OFF_CLEAR, 16'h000f, OFF_DATA, 16'h0ff0},
    '{OFF_TOGGLE, 16'hff00, OFF_DATA, 16'hf0f0},
    '{OFF_MASK_SET, 16'h0003, OFF_MASK, 16'h0003},
    '{OFF_MASK_SET, 16'h0030, OFF_MASK, 16'h0033},
    '{OFF_MASK_CLR, 16'h0001, OFF_MASK, 16'h0032},
    '{OFF_DIR, 16'hffff, OFF_DIR, 16'hffff},
    '{OFF_MASK, 16'h0030, OFF_MASK, 16'h0030}};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [47:0] drive = 48'h0;
  logic [47:0] po = 48'h0;
  logic [47:0] poe = 48'h0;
  logic [15:0] pj_in = 16'h0;
  logic [15:0] pj_po = 16'h0;
  logic [15:0] pj_poe = 16'h0;
  wire logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic [47:0] pin_in, pin_out, pin_oe, pio;
  logic [15:0] pj_out, pj_oe, pj_pio;
  logic [2:0] irq;
  int miscompares = 0;
  int n_tests = 0;
  // System clock, 100 MHz
  always #5 clk = ~clk;
  gpio_port_bank gpio_port_bank_inst (
    .REF_CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(1'b1), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .PIN_IN(pin_in),
    .PIN_OUT(pin_out), .PIN_OE_OUT(pin_oe), .PERIPH_OUT_IN(po),
    .PERIPH_OE_IN(poe), .PERIPH_IN_OUT(pio), .PJ_PIN_IN(pj_in),
    .PJ_PIN_OUT(pj_out), .PJ_PIN_OE_OUT(pj_oe), .PJ_PERIPH_OUT_IN(pj_po),
    .PJ_PERIPH_OE_IN(pj_poe), .PJ_PERIPH_IN_OUT(pj_pio), .IRQ_OUT(irq));
  board_model board_model_inst (
    .pin_out_in(pin_out), .pin_oe_in(pin_oe), .drive_in(drive),
    .pin_level_out(pin_in));
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t read %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_out(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t output %h expected %h", $time, g, e);
    end
  endtask
  // One single AHB-Lite transfer; outputs are seen before the edge lands
  task automatic bus(input logic w, input logic [1:0] p, input logic [5:0] o,
                     input logic [15:0] d, output logic [31:0] q);
    haddr <= {24'h0, p, o};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [1:0] p, input logic [5:0] o,
                    input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, p, o, d, q);
  endtask
  task automatic rd(input logic [1:0] p, input logic [5:0] o,
                    input logic [15:0] e);
    logic [31:0] q;
    bus(1'b0, p, o, 16'h0, q);
    cmp_rd(q, {16'h0, e});
  endtask
  // Wait a bounded span for an interrupt line to reach a level
  task automatic wait_irq(input int p, input logic v);
    for (int i = 0; i < 20 && irq[p] !== v; i++) @(posedge clk);
    cmp_out({15'h0, irq[p]}, {15'h0, v});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Cuts a hang short
  initial begin
    #200000;
    miscompares++;
    end_sim();
  end
  // Main sequence
  initial begin
    idle(2);
    rstn <= 1'b1;
    idle(1);
    foreach (ROWS[i]) begin
      wr(2'h0, ROWS[i].wo, ROWS[i].wd);
      rd(2'h0, ROWS[i].ro, ROWS[i].ex);
    end
    idle(2);
    cmp_out(pin_out[15:0], 16'hf0f0);
    cmp_out(pin_oe[15:0], 16'hffff);
    cmp_out(pin_oe[31:16], 16'h0000);
    // Masked output pins at a high level hold the first port's request
    cmp_out({15'h0, irq[0]}, 16'h0001);
    // Each port module holds its own data word, the fourth has none
    for (int p = 1; p < 3; p++) begin
      wr(p[1:0], OFF_DATA, 16'ha5a0 | p[15:0]);
      rd(p[1:0], OFF_DATA, 16'ha5a0 | p[15:0]);
    end
    wr(2'h3, OFF_DATA, 16'hffff);
    rd(2'h3, OFF_DATA, 16'h0000);
    rd(2'h0, 6'h38, 16'h0000);
    // Sensed level stays off until the input buffer is enabled
    drive[31:16] <= 16'h1234;
    idle(4);
    rd(2'h1, OFF_STATUS, 16'h0000);
    wr(2'h1, OFF_INEN, 16'hffff);
    idle(4);
    rd(2'h1, OFF_STATUS, 16'h1234);
    drive[31:16] <= 16'h4321;
    idle(3);
    rd(2'h1, OFF_STATUS, 16'h4321);
    // Level interrupt on a high input, then masked off
    wr(2'h1, OFF_MASK_SET, 16'h0001);
    wait_irq(1, 1'b1);
    wr(2'h1, OFF_MASK_CLR, 16'h0001);
    wait_irq(1, 1'b0);
    // Edge interrupt on bit 1, rising only, then both edges
    wr(2'h1, OFF_SENS, 16'h0002);
    wr(2'h1, OFF_MASK_SET, 16'h0002);
    drive[17] <= 1'b1;
    wait_irq(1, 1'b1);
    wr(2'h1, OFF_FLAG, 16'h0002);
    idle(4);
    cmp_out({15'h0, irq[1]}, 16'h0000);
    drive[17] <= 1'b0;
    idle(8);
    cmp_out({15'h0, irq[1]}, 16'h0000);
    wr(2'h1, OFF_BOTH, 16'h0002);
    drive[17] <= 1'b1;
    wait_irq(1, 1'b1);
    wr(2'h1, OFF_FLAG, 16'h0002);
    wait_irq(1, 1'b0);
    drive[17] <= 1'b0;
    wait_irq(1, 1'b1);
    rd(2'h1, OFF_FLAG, 16'h0002);
    // Output pin raises its interrupt through a software write
    wr(2'h2, OFF_DIR, 16'h0001);
    wr(2'h2, OFF_MASK_SET, 16'h0001);
    wr(2'h2, OFF_DATA, 16'h0000);
    idle(4);
    cmp_out({15'h0, irq[2]}, 16'h0000);
    wr(2'h2, OFF_DATA, 16'h0001);
    wait_irq(2, 1'b1);
    // Shared pin handed to its peripheral, hidden from the status word
    drive[40] <= 1'b1;
    wr(2'h2, OFF_INEN, 16'h0100);
    wr(2'h2, OFF_FUNC, 16'h0100);
    idle(4);
    cmp_out(pio[47:32], 16'h0100);
    cmp_out(pin_oe[47:32], 16'h0001);
    rd(2'h2, OFF_STATUS, 16'h0000);
    po[40] <= 1'b1;
    poe[40] <= 1'b1;
    idle(2);
    cmp_out(pin_out[47:32], 16'h0101);
    cmp_out(pin_oe[47:32], 16'h0101);
    // Fourth port only passes peripheral signals
    pj_po <= 16'hbeef;
    pj_poe <= 16'h00ff;
    pj_in <= 16'h5a5a;
    idle(3);
    cmp_out(pj_out, 16'hbeef);
    cmp_out(pj_oe, 16'h00ff);
    cmp_out(pj_pio, 16'h5a5a);
    // Second reset in mid-run clears control state
    rstn <= 1'b0;
    idle(2);
    rstn <= 1'b1;
    idle(1);
    cmp_out(pin_oe[15:0], 16'h0000);
    cmp_out(pio[47:32], 16'h0000);
    cmp_out(pin_oe[47:32], 16'h0000);
    cmp_out({15'h0, irq[2]}, 16'h0000);
    rd(2'h0, OFF_DIR, 16'h0000);
    rd(2'h1, OFF_FUNC, 16'h0000);
    rd(2'h1, OFF_INEN, 16'h0000);
    rd(2'h0, OFF_MASK, 16'h0000);
    cmp_out({15'h0, hresp}, 16'h0000);
    end_sim();
  end
endmodule
